/* core/plap_defines.svh */
// Offsets, field positions, reset values and sizes for the palette access port.
// Assumes inclusion by the colour store, the main module and the bench.
`ifndef PLAP_DEFINES_SVH
`define PLAP_DEFINES_SVH
`define PLAP_ADR_MASK 16'h03C6
`define PLAP_ADR_STATE 16'h03C7
`define PLAP_ADR_WPTR 16'h03C8
`define PLAP_ADR_DATA 16'h03C9
`define PLAP_MASK_RST 8'hFF
`define PLAP_PTR_RST 8'h00
`define PLAP_STATE_WR 2'h0
`define PLAP_STATE_RD 2'h2
`define PLAP_MAIN_DEPTH 256
`define PLAP_CURS_DEPTH 8
`define PLAP_CURS_IDX_W 3
`define PLAP_R_LSB 16
`define PLAP_G_LSB 8
`define PLAP_B_LSB 0
`endif

/* core/plap_pkg.sv */
// Types shared by the palette access port modules.
// Assumes the defines header sits beside it.
package plap_pkg;
   typedef logic [7:0] plap_byte_t;
   typedef struct packed
   {
      plap_byte_t red;
      plap_byte_t green;
      plap_byte_t blue;
   } plap_rgb_s;
   typedef enum logic [2:0]
   {
      PLAP_RED = 3'h1,
      PLAP_GREEN = 3'h2,
      PLAP_BLUE = 3'h4
   } plap_comp_e;
endpackage : plap_pkg

/* core/plap_colour_store.sv */
// Dual-set colour storage: 256 main entries and 8 cursor entries.
// Assumes one whole-entry commit per cycle; pixel lookup output is registered.
`include "plap_defines.svh"
module plap_colour_store
   import plap_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic wr_en,
   input wire logic wr_curs,
   input wire logic [7:0] wr_idx,
   input wire plap_rgb_s wr_rgb,
   input wire logic [7:0] rd_idx,
   input wire logic rd_curs,
   output plap_rgb_s rd_rgb,
   input wire logic [7:0] pix_idx,
   output plap_rgb_s pix_rgb
);
   plap_rgb_s main_mem [`PLAP_MAIN_DEPTH];
   plap_rgb_s curs_mem [`PLAP_CURS_DEPTH];
   wire logic [2:0] wr_cidx = wr_idx[`PLAP_CURS_IDX_W-1:0];
   wire logic [2:0] rd_cidx = rd_idx[`PLAP_CURS_IDX_W-1:0];

   // Whole entry written in one cycle, never piecemeal
   always_ff @(posedge SYS_CLK)
   begin
      if (wr_en && !wr_curs)
         main_mem[wr_idx] <= wr_rgb; // RULE_09
      if (wr_en && wr_curs)
         curs_mem[wr_cidx] <= wr_rgb; // RULE_11
   end

   // Host read path is combinational so the data port answers in the same cycle
   assign rd_rgb = rd_curs ? curs_mem[rd_cidx] : main_mem[rd_idx]; // RULE_11

   always_ff @(posedge SYS_CLK)
   begin
      pix_rgb <= main_mem[pix_idx]; // RULE_01
   end
endmodule // plap_colour_store

/* core/plap_access_port.sv */
// Palette access port: host byte registers, component sequencing and pixel path.
// Assumes a synchronous host I/O strobe pair on SYS_CLK; pixels arrive on SYS_CLK.
//
// What this block does
// RULE_01: Holds 256 entries of 24-bit colour.
// RULE_02: Indexed mode looks up masked 8-bit pixel.
// RULE_03: Direct mode takes colour from pixel fields.
// RULE_04: Index equals pixel ANDed with mask.
// RULE_05: Direct mode ignores the mask.
// RULE_06: Data reads return red, green, blue.
// RULE_07: Read pointer increments after third read.
// RULE_08: Host writes pointer, then red, green, blue.
// RULE_09: Entry commits only after all three bytes.
// RULE_10: Write pointer increments after third write.
// RULE_11: Config bit selects eight cursor entries.
// RULE_12: State reads 00 after write, 10 after read pointer.
// RULE_13: Shared address: write read pointer, read state.
// RULE_14: One data port, direction picks pointer.
// RULE_15: Any pointer write restarts at red.
// RULE_16: Host avoids pointer writes mid-sequence.
// RULE_17: Pointers wrap; sequencer resets to red.
// RULE_18: Partial writes staged away from the palette.
`include "plap_defines.svh"
module plap_access_port
   import plap_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [15:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [7:0] IO_WDATA,
   output logic [7:0] IO_RDATA,
   input wire logic CURSOR_SET_SEL,
   input wire logic DIRECT_MODE,
   input wire logic [23:0] PIXEL_IN,
   output plap_rgb_s PIXEL_RGB
);
   // ****************************************
   // Register decode
   // ****************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      return a == o;
   endfunction

   wire logic wr_mask = IO_WR && hit(IO_ADDR, `PLAP_ADR_MASK);
   wire logic wr_rptr = IO_WR && hit(IO_ADDR, `PLAP_ADR_STATE); // RULE_13
   wire logic wr_wptr = IO_WR && hit(IO_ADDR, `PLAP_ADR_WPTR);
   wire logic wr_data = IO_WR && hit(IO_ADDR, `PLAP_ADR_DATA); // RULE_14
   wire logic rd_data = IO_RD && hit(IO_ADDR, `PLAP_ADR_DATA); // RULE_14
   wire logic ptr_load = wr_rptr || wr_wptr;

   plap_byte_t pixel_index_mask;
   plap_byte_t lookup_read_pointer;
   plap_byte_t lookup_write_pointer;
   logic [1:0] pointer_state;
   plap_comp_e rd_comp;
   plap_comp_e wr_comp;
   plap_byte_t stage_red;
   plap_byte_t stage_green;

   // ****************************************
   // Component sequencers
   // ****************************************
   // Separate read and write sequencers; a pointer load restarts both, since the
   // shared cycling circuit is reset by either pointer.
   function automatic plap_comp_e step(input plap_comp_e c);
      case (c)
         PLAP_RED: return PLAP_GREEN;
         PLAP_GREEN: return PLAP_BLUE;
         PLAP_BLUE: return PLAP_RED;
         default: return PLAP_RED;
      endcase
   endfunction

   function automatic plap_byte_t wrap_inc(input plap_byte_t p, input logic curs);
      plap_byte_t n;
      n = p + 8'h01;
      if (curs)
         n = {5'h00, n[`PLAP_CURS_IDX_W-1:0]};
      return n;
   endfunction

   wire plap_comp_e next_rd_comp = ptr_load ? PLAP_RED : (rd_data ? step(rd_comp) : rd_comp);
   wire plap_comp_e next_wr_comp = ptr_load ? PLAP_RED : (wr_data ? step(wr_comp) : wr_comp);
   wire logic rd_last = rd_data && !ptr_load && rd_comp == PLAP_BLUE;
   wire logic wr_last = wr_data && !ptr_load && wr_comp == PLAP_BLUE;

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         rd_comp <= PLAP_RED; // RULE_17
         wr_comp <= PLAP_RED; // RULE_17
      end
      else
      begin
         rd_comp <= next_rd_comp; // RULE_15
         wr_comp <= next_wr_comp; // RULE_15
      end
   end

   // ****************************************
   // Pointers, mask and state
   // ****************************************
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         pixel_index_mask <= `PLAP_MASK_RST;
         lookup_read_pointer <= `PLAP_PTR_RST;
         lookup_write_pointer <= `PLAP_PTR_RST;
         pointer_state <= `PLAP_STATE_WR;
      end
      else
      begin
         if (wr_mask)
            pixel_index_mask <= IO_WDATA;
         if (wr_rptr)
         begin
            lookup_read_pointer <= IO_WDATA;
            pointer_state <= `PLAP_STATE_RD; // RULE_12
         end
         else if (rd_last)
            lookup_read_pointer <= wrap_inc(lookup_read_pointer, CURSOR_SET_SEL); // RULE_07
         if (wr_wptr)
         begin
            lookup_write_pointer <= IO_WDATA;
            pointer_state <= `PLAP_STATE_WR; // RULE_12
         end
         else if (wr_last)
            lookup_write_pointer <= wrap_inc(lookup_write_pointer, CURSOR_SET_SEL); // RULE_10
      end
   end

   // Red and green wait here so a lookup never sees a half-written entry
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         stage_red <= 8'h00;
         stage_green <= 8'h00;
      end
      else
      begin
         if (wr_data && wr_comp == PLAP_RED)
            stage_red <= IO_WDATA; // RULE_18
         if (wr_data && wr_comp == PLAP_GREEN)
            stage_green <= IO_WDATA; // RULE_18
      end
   end

   // ****************************************
   // Storage and lookup
   // ****************************************
   wire plap_rgb_s commit_rgb = '{red: stage_red, green: stage_green, blue: IO_WDATA};
   wire plap_byte_t pix_index = PIXEL_IN[7:0] & pixel_index_mask; // RULE_04
   plap_rgb_s host_rgb;
   plap_rgb_s lut_rgb;

   plap_colour_store u_store
   (
      .SYS_CLK(SYS_CLK),
      .wr_en(wr_last), // RULE_09
      .wr_curs(CURSOR_SET_SEL),
      .wr_idx(lookup_write_pointer),
      .wr_rgb(commit_rgb),
      .rd_idx(lookup_read_pointer),
      .rd_curs(CURSOR_SET_SEL),
      .rd_rgb(host_rgb),
      .pix_idx(pix_index),
      .pix_rgb(lut_rgb)
   );

   // Direct pixels are delayed one stage to line up with the table read
   plap_rgb_s direct_rgb;
   logic direct_q;
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         direct_rgb <= '0;
         direct_q <= 1'b0;
      end
      else
      begin
         direct_rgb <= '{red: PIXEL_IN[`PLAP_R_LSB +: 8], green: PIXEL_IN[`PLAP_G_LSB +: 8],
                         blue: PIXEL_IN[`PLAP_B_LSB +: 8]}; // RULE_03
         direct_q <= DIRECT_MODE;
      end
   end

   assign PIXEL_RGB = direct_q ? direct_rgb : lut_rgb; // RULE_02 RULE_05

   // ****************************************
   // Read-back
   // ****************************************
   wire plap_byte_t comp_byte = (rd_comp == PLAP_RED) ? host_rgb.red :
                                (rd_comp == PLAP_GREEN) ? host_rgb.green : host_rgb.blue; // RULE_06
   always_comb
   begin
      IO_RDATA = 8'h00;
      if (IO_RD)
      begin
         case (IO_ADDR)
            `PLAP_ADR_MASK: IO_RDATA = pixel_index_mask;
            `PLAP_ADR_STATE: IO_RDATA = {6'h00, pointer_state}; // RULE_13
            `PLAP_ADR_WPTR: IO_RDATA = lookup_write_pointer;
            `PLAP_ADR_DATA: IO_RDATA = comp_byte; // RULE_14
            default: IO_RDATA = 8'h00;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // Red and green steps of a triple, taken only when no pointer load restarts it
   sequence rd_red_s;
      rd_data && !ptr_load && rd_comp == PLAP_RED;
   endsequence
   sequence rd_green_s;
      rd_data && !ptr_load && rd_comp == PLAP_GREEN;
   endsequence
   sequence wr_red_s;
      wr_data && !ptr_load && wr_comp == PLAP_RED;
   endsequence
   sequence wr_green_s;
      wr_data && !ptr_load && wr_comp == PLAP_GREEN;
   endsequence

   rptr_incr_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_07
      rd_last && !wr_rptr |=> lookup_read_pointer ==
         wrap_inc($past(lookup_read_pointer), $past(CURSOR_SET_SEL)))
      else $error("read pointer did not advance");
   wptr_incr_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_10
      wr_last |=> lookup_write_pointer ==
         wrap_inc($past(lookup_write_pointer), $past(CURSOR_SET_SEL)))
      else $error("write pointer did not advance");
   seq_restart_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_15
      ptr_load |=> rd_comp == PLAP_RED && wr_comp == PLAP_RED)
      else $error("pointer write did not restart at red");
   state_rd_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_12
      wr_rptr && !wr_wptr |=> pointer_state == `PLAP_STATE_RD)
      else $error("state not read code");
   state_wr_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_12
      wr_wptr |=> pointer_state == `PLAP_STATE_WR)
      else $error("state not write code");
   comp_order_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_06
      rd_red_s |=> rd_comp == PLAP_GREEN)
      else $error("component order broken");
   rd_green_step_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_06
      rd_green_s |=> rd_comp == PLAP_BLUE)
      else $error("read did not move to blue");
   rd_blue_wrap_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_06
      rd_last |=> rd_comp == PLAP_RED)
      else $error("read did not return to red");
   wr_red_step_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_09
      wr_red_s |=> wr_comp == PLAP_GREEN)
      else $error("write did not move to green");
   wr_green_step_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_09
      wr_green_s |=> wr_comp == PLAP_BLUE)
      else $error("write did not move to blue");
   stage_red_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_18
      wr_red_s |=> stage_red == $past(IO_WDATA))
      else $error("red byte not staged");
   stage_green_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_18
      wr_green_s |=> stage_green == $past(IO_WDATA))
      else $error("green byte not staged");
   rd_red_byte_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_06
      rd_red_s |-> IO_RDATA == host_rgb.red)
      else $error("first read is not red");
   rd_green_byte_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_06
      rd_green_s |-> IO_RDATA == host_rgb.green)
      else $error("second read is not green");
   rd_blue_byte_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_06
      rd_last |-> IO_RDATA == host_rgb.blue)
      else $error("third read is not blue");
   mask_and_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_04
      pix_index == (PIXEL_IN[7:0] & pixel_index_mask))
      else $error("index not masked");
   direct_out_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_03
      DIRECT_MODE |=> PIXEL_RGB == $past(PIXEL_IN))
      else $error("direct colour not passed");
   no_partial_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_09
      wr_data && wr_comp != PLAP_BLUE |-> !wr_last)
      else $error("entry committed early");
   state_read_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_13
      IO_RD && IO_ADDR == `PLAP_ADR_STATE |-> IO_RDATA == {6'h00, pointer_state})
      else $error("state address did not return state");
   state_code_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_12
      pointer_state == `PLAP_STATE_WR || pointer_state == `PLAP_STATE_RD)
      else $error("state holds an undefined code");
   idle_rdata_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_13
      !IO_RD |-> IO_RDATA == 8'h00)
      else $error("read data shown without a read");
   mask_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_04
      !wr_mask |=> $stable(pixel_index_mask))
      else $error("mask changed without a write");
   mask_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_04
      (pix_index & ~pixel_index_mask) == 8'h00)
      else $error("masked index bit not forced low");
   wptr_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_10
      !wr_wptr && !wr_last |=> $stable(lookup_write_pointer))
      else $error("write pointer moved without cause");
   rptr_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE_07
      !wr_rptr && !rd_last |=> $stable(lookup_read_pointer))
      else $error("read pointer moved without cause");
endmodule // plap_access_port

/* tb/plap_host_model.sv */
// Host processor model: byte-wide I/O reads and writes to the access port.
// Assumes the port takes strobes on the rising edge of SYS_CLK.
module plap_host_model
(
   input wire logic SYS_CLK,
   output logic [15:0] IO_ADDR,
   output logic IO_WR,
   output logic IO_RD,
   output logic [7:0] IO_WDATA,
   input wire logic [7:0] IO_RDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      IO_ADDR = 16'h0000;
      IO_WR = 1'h0;
      IO_RD = 1'h0;
      IO_WDATA = 8'h00;
   end
   // Pointer first, then red, green, blue; a mid-triple pointer write is only
   // issued where a test wants the restart
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      IO_ADDR <= a;
      IO_WDATA <= d;
      IO_WR <= 1'h1;
      @(posedge SYS_CLK);
      IO_WR <= 1'h0;
      // Released lines show no stale value
      IO_ADDR <= ~a;
      IO_WDATA <= ~d;
   endtask
   task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge SYS_CLK);
      IO_ADDR <= a;
      IO_RD <= 1'h1;
      @(posedge SYS_CLK);
      d = IO_RDATA;
      IO_RD <= 1'h0;
      IO_ADDR <= ~a;
   endtask
endmodule // plap_host_model

/* tb/plap_access_port_bench.sv */
// Self-checking bench for the palette access port.
// Assumes the host model drives the I/O side and the defines header is on the path.
`include "plap_defines.svh"
module plap_access_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic SYS_CLK, RST, CURSOR_SET_SEL, DIRECT_MODE, IO_WR, IO_RD;
   logic [15:0] IO_ADDR;
   logic [7:0] IO_WDATA, IO_RDATA, m, b, s;
   logic [23:0] PIXEL_IN, c, pal [256], cur [8];
   plap_pkg::plap_rgb_s pix_rgb;
   int error_cnt = 0;
   int checks = 0;
   plap_access_port dut (.SYS_CLK(SYS_CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
      .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
      .CURSOR_SET_SEL(CURSOR_SET_SEL), .DIRECT_MODE(DIRECT_MODE), .PIXEL_IN(PIXEL_IN),
      .PIXEL_RGB(pix_rgb));
   plap_host_model host (.SYS_CLK(SYS_CLK), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
      .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic put(input logic [23:0] v);
      host.io_wr(`PLAP_ADR_DATA, v[23:16]);
      host.io_wr(`PLAP_ADR_DATA, v[15:8]);
      host.io_wr(`PLAP_ADR_DATA, v[7:0]);
   endtask
   task automatic get(output logic [23:0] v);
      host.io_rd(`PLAP_ADR_DATA, v[23:16]);
      host.io_rd(`PLAP_ADR_DATA, v[15:8]);
      host.io_rd(`PLAP_ADR_DATA, v[7:0]);
   endtask
   function automatic logic [23:0] f_pix(input logic [23:0] p, input logic d);
      return d ? p : pal[p[7:0] & m];
   endfunction
   task automatic px(input logic [23:0] p, input logic d);
      @(posedge SYS_CLK);
      PIXEL_IN <= p;
      DIRECT_MODE <= d;
      @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk(pix_rgb, f_pix(p, d));
   endtask
   initial
   begin
      SYS_CLK = 1'h0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   initial
   begin
      repeat (60000) @(posedge SYS_CLK);
      error_cnt++;
      end_sim();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      RST = 1'h1;
      CURSOR_SET_SEL = 1'h0;
      DIRECT_MODE = 1'h0;
      PIXEL_IN = 24'h000000;
      m = 8'hFF;
      void'($urandom(32'h784B1433));
      repeat (3) @(posedge SYS_CLK);
      RST <= 1'h0;
      host.io_rd(`PLAP_ADR_MASK, b);
      chk(b, 8'hFF);
      host.io_rd(`PLAP_ADR_STATE, b);
      chk(b[1:0], 2'h0);
      host.io_rd(`PLAP_ADR_WPTR, b);
      chk(b, 8'h00);
      host.io_rd(16'h03C5, b);
      chk(b, 8'h00);
      $display("test reset done");
      s = 8'($urandom);
      host.io_wr(`PLAP_ADR_WPTR, s);
      for (int i = 0; i < 256; i++)
      begin
         c = 24'($urandom);
         pal[8'(s + i)] = c;
         put(c);
      end
      host.io_rd(`PLAP_ADR_WPTR, b);
      chk(b, s);
      host.io_wr(`PLAP_ADR_STATE, 8'hFF);
      host.io_rd(`PLAP_ADR_STATE, b);
      chk(b[1:0], 2'h2);
      for (int i = 0; i < 3; i++)
      begin
         get(c);
         chk(c, pal[8'(8'hFF + i)]);
      end
      $display("test stream done");
      host.io_wr(`PLAP_ADR_WPTR, 8'h10);
      host.io_rd(`PLAP_ADR_STATE, b);
      chk(b[1:0], 2'h0);
      host.io_wr(`PLAP_ADR_DATA, 8'h5A);
      host.io_wr(`PLAP_ADR_DATA, 8'hA5);
      px(24'h000010, 1'h0);
      host.io_wr(`PLAP_ADR_STATE, 8'h10);
      host.io_rd(`PLAP_ADR_DATA, b);
      chk(b, pal[8'h10][23:16]);
      host.io_wr(`PLAP_ADR_STATE, 8'h10);
      get(c);
      chk(c, pal[8'h10]);
      host.io_wr(`PLAP_ADR_WPTR, 8'h10);
      pal[8'h10] = 24'($urandom);
      put(pal[8'h10]);
      host.io_wr(`PLAP_ADR_STATE, 8'h10);
      get(c);
      chk(c, pal[8'h10]);
      $display("test restart done");
      m = 8'($urandom);
      host.io_wr(`PLAP_ADR_MASK, m);
      host.io_rd(`PLAP_ADR_MASK, b);
      chk(b, m);
      for (int i = 0; i < 40; i++)
         px(24'($urandom), 1'($urandom));
      $display("test pixel done");
      @(posedge SYS_CLK);
      CURSOR_SET_SEL <= 1'h1;
      host.io_wr(`PLAP_ADR_WPTR, 8'h07);
      for (int i = 0; i < 2; i++)
      begin
         cur[3'(7 + i)] = 24'($urandom);
         put(cur[3'(7 + i)]);
      end
      host.io_wr(`PLAP_ADR_STATE, 8'h07);
      for (int i = 0; i < 2; i++)
      begin
         get(c);
         chk(c, cur[3'(7 + i)]);
      end
      CURSOR_SET_SEL <= 1'h0;
      host.io_wr(`PLAP_ADR_STATE, 8'h07);
      get(c);
      chk(c, pal[8'h07]);
      $display("test cursor done");
      end_sim();
   end
endmodule // plap_access_port_bench
